// ---- hw/dma_chan_cfg.svh ----
// Purpose: Address map, field positions and reset values of the channel register block.
// Assumes: Byte addresses on a 32-bit APB; only paddr[11:0] is decoded.
// Notes: Offsets inside a channel block are byte offsets from the block base.
`ifndef DMA_CHAN_CFG_SVH
`define DMA_CHAN_CFG_SVH

`define CHAN_COUNT 12
`define CHAN_STRIDE 12'h040
`define OFF_SOURCE 6'h00
`define OFF_DEST 6'h04
`define OFF_TALLY 6'h08
`define OFF_CONTROL 6'h0c
`define OFF_TALLY_TRIG 6'h1c
`define DBG_REGION 2'h2
`define OFF_RELOAD_DBG 6'h04
`define ADDR_INTR_STATUS 12'h400
`define ADDR_INTR_MASK 12'h404

`define BIT_FAULT_ANY 31
`define BIT_FAULT_READ 30
`define BIT_FAULT_WRITE 29
`define BIT_BUSY 24
`define BIT_ENABLE 0

`define PTR_RESET 32'h00000000
`define TALLY_RESET 32'h00000000
`define XFER_BYTES 32'h00000004

`endif

// ---- hw/dma_chan_pkg.sv ----
// Purpose: Types shared by the channel core and its bench.
// Assumes: Nothing beyond the configuration header.
// Notes: State codes are one-hot.
`default_nettype none
package dma_chan_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } eng_state_type;

  typedef enum logic [3:0] {
    SEL_NONE, SEL_SOURCE, SEL_DEST, SEL_TALLY, SEL_CONTROL,
    SEL_TALLY_TRIG, SEL_RELOAD_DBG, SEL_INTR_STATUS, SEL_INTR_MASK
  } sel_type;

  typedef struct packed {
    sel_type sel;
    logic [3:0] ch;
  } decode_type;

  typedef struct packed {
    logic req;
    logic [31:0] addr;
  } bus_req_type;

endpackage
`default_nettype wire

// ---- hw/dma_chan_core.sv ----
// Purpose: Pointer, transfer count and control/status core of a multi-channel DMA engine.
// Assumes: One clock; bus answers (ack, err) come from logic on the same clock.
// Notes: One transfer in flight at a time, lowest ready channel first.
`include "dma_chan_cfg.svh"
`default_nettype none
module dma_chan_core #(
  parameter int NUM_CH = `CHAN_COUNT
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System bus read side
  output dma_chan_pkg::bus_req_type rd_req,
  input wire logic rd_ack,
  input wire logic rd_err,
  input wire logic [31:0] rd_data,
  // System bus write side
  output dma_chan_pkg::bus_req_type wr_req,
  output logic [31:0] wr_data,
  input wire logic wr_ack,
  input wire logic wr_err,
  // Interrupt
  output logic irq
);

  if (NUM_CH < 1 || NUM_CH > 16) begin : g_bad_num_ch
    $error("NUM_CH must lie between 1 and 16.");
  end

  logic [31:0] src_r [NUM_CH];
  logic [31:0] dst_r [NUM_CH];
  logic [31:0] live_r [NUM_CH];
  logic [31:0] reload_r [NUM_CH];
  logic [NUM_CH-1:0] en_r, busy_r, rerr_r, werr_r, stat_r, mask_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r, irq_r;
  dma_chan_pkg::bus_req_type rd_r, wr_r;
  logic [31:0] wr_data_r;
  dma_chan_pkg::eng_state_type state_r;
  logic [3:0] cur_r;

  function automatic dma_chan_pkg::decode_type decode(input logic [11:0] a);
    dma_chan_pkg::decode_type d;
    d.sel = dma_chan_pkg::SEL_NONE;
    d.ch = a[9:6];
    if (a[11:10] == 2'h0 && 32'(a[9:6]) < NUM_CH) begin
      case (a[5:0])
        `OFF_SOURCE: d.sel = dma_chan_pkg::SEL_SOURCE;
        `OFF_DEST: d.sel = dma_chan_pkg::SEL_DEST;
        `OFF_TALLY: d.sel = dma_chan_pkg::SEL_TALLY;
        `OFF_CONTROL: d.sel = dma_chan_pkg::SEL_CONTROL;
        `OFF_TALLY_TRIG: d.sel = dma_chan_pkg::SEL_TALLY_TRIG;
        default: d.sel = dma_chan_pkg::SEL_NONE;
      endcase
    end else if (a[11:10] == `DBG_REGION && 32'(a[9:6]) < NUM_CH
                 && a[5:0] == `OFF_RELOAD_DBG) begin
      d.sel = dma_chan_pkg::SEL_RELOAD_DBG;
    end else if (a == `ADDR_INTR_STATUS) begin
      d.sel = dma_chan_pkg::SEL_INTR_STATUS;
    end else if (a == `ADDR_INTR_MASK) begin
      d.sel = dma_chan_pkg::SEL_INTR_MASK;
    end
    return d;
  endfunction

  dma_chan_pkg::decode_type wd, rd_dec;
  logic wr_en;
  assign wd = decode(paddr);
  assign rd_dec = wd;
  // Writes land only at the access edge that the master sees pready high.
  assign wr_en = psel && penable && pwrite && pready_r && !pslverr_r;

  function automatic logic hit(input dma_chan_pkg::sel_type s, input int i);
    return wr_en && wd.sel == s && 32'(wd.ch) == i;
  endfunction

  // Engine events.
  logic rd_done, rd_fail, wr_done, wr_fail, last_xfer;
  assign rd_fail = state_r == dma_chan_pkg::ST_READ && rd_err;
  assign rd_done = state_r == dma_chan_pkg::ST_READ && rd_ack && !rd_err;
  assign wr_fail = state_r == dma_chan_pkg::ST_WRITE && wr_err;
  assign wr_done = state_r == dma_chan_pkg::ST_WRITE && wr_ack && !wr_err;
  assign last_xfer = live_r[cur_r] == 32'h1;

  // Triggers: control write with enable set, or the count-trigger alias.
  logic [NUM_CH-1:0] trig, set_rerr, set_werr, set_intr, w1c_ctrl, w1c_stat;
  logic [31:0] trig_len [NUM_CH];
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      trig[i] = !busy_r[i] && ((hit(dma_chan_pkg::SEL_CONTROL, i) && pwdata[`BIT_ENABLE])
                || hit(dma_chan_pkg::SEL_TALLY_TRIG, i));
      trig_len[i] = hit(dma_chan_pkg::SEL_TALLY_TRIG, i) ? pwdata : reload_r[i];
      set_rerr[i] = rd_fail && 32'(cur_r) == i;
      set_werr[i] = wr_fail && 32'(cur_r) == i;
      set_intr[i] = set_rerr[i] || set_werr[i] || (wr_done && last_xfer && 32'(cur_r) == i)
                    || (trig[i] && trig_len[i] == `TALLY_RESET);
      w1c_ctrl[i] = hit(dma_chan_pkg::SEL_CONTROL, i);
      w1c_stat[i] = wr_en && wd.sel == dma_chan_pkg::SEL_INTR_STATUS && pwdata[i];
    end
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (!rst_n) begin
        src_r[i] <= `PTR_RESET;
      end else if (hit(dma_chan_pkg::SEL_SOURCE, i)) begin
        src_r[i] <= pwdata;
      end else if (rd_done && 32'(cur_r) == i) begin
        src_r[i] <= src_r[i] + `XFER_BYTES;
      end
    end
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (!rst_n) begin
        dst_r[i] <= `PTR_RESET;
      end else if (hit(dma_chan_pkg::SEL_DEST, i)) begin
        dst_r[i] <= pwdata;
      end else if (wr_done && 32'(cur_r) == i) begin
        dst_r[i] <= dst_r[i] + `XFER_BYTES;
      end
    end
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (!rst_n) begin
        reload_r[i] <= `TALLY_RESET;
      end else if (hit(dma_chan_pkg::SEL_TALLY, i) || hit(dma_chan_pkg::SEL_TALLY_TRIG, i)) begin
        reload_r[i] <= pwdata;
      end
    end
  end

  always_ff @(posedge mclk) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (!rst_n) begin
        live_r[i] <= `TALLY_RESET;
      end else if (trig[i]) begin
        live_r[i] <= trig_len[i];
      end else if (wr_done && 32'(cur_r) == i) begin
        live_r[i] <= live_r[i] - 32'h1;
      end
    end
  end

  // busy flag; only completion, a fault or a trigger move it.
  always_ff @(posedge mclk) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (!rst_n) begin
        busy_r[i] <= 1'b0;
      end else if (trig[i]) begin
        busy_r[i] <= trig_len[i] != `TALLY_RESET;
      end else if (set_rerr[i] || set_werr[i] || (wr_done && last_xfer && 32'(cur_r) == i)) begin
        busy_r[i] <= 1'b0;
      end
    end
  end

  // fault flags; a new fault wins over a clear in the same cycle.
  always_ff @(posedge mclk) begin
    for (int i = 0; i < NUM_CH; i++) begin
      if (!rst_n) begin
        rerr_r[i] <= 1'b0;
        werr_r[i] <= 1'b0;
        en_r[i] <= 1'b0;
      end else begin
        rerr_r[i] <= set_rerr[i] || (rerr_r[i] && !(w1c_ctrl[i] && pwdata[`BIT_FAULT_READ]));
        werr_r[i] <= set_werr[i] || (werr_r[i] && !(w1c_ctrl[i] && pwdata[`BIT_FAULT_WRITE]));
        if (w1c_ctrl[i]) begin
          en_r[i] <= pwdata[`BIT_ENABLE];
        end
      end
    end
  end

  // Interrupt status, mask and output.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stat_r <= '0;
      mask_r <= '0;
      irq_r <= 1'b0;
    end else begin
      stat_r <= (stat_r & ~w1c_stat) | set_intr;
      if (wr_en && wd.sel == dma_chan_pkg::SEL_INTR_MASK) begin
        mask_r <= pwdata[NUM_CH-1:0];
      end
      irq_r <= |(stat_r & mask_r);
    end
  end

  // a channel without enable is not picked, so it pauses busy.
  logic [3:0] pick;
  logic pick_ok;
  always_comb begin
    pick = 4'h0;
    pick_ok = 1'b0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (busy_r[i] && en_r[i]) begin
        pick = 4'(i);
        pick_ok = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r <= dma_chan_pkg::ST_IDLE;
      cur_r <= 4'h0;
      rd_r <= '0;
      wr_r <= '0;
      wr_data_r <= 32'h00000000;
    end else begin
      case (state_r)
        dma_chan_pkg::ST_IDLE: begin
          if (pick_ok) begin
            cur_r <= pick;
            rd_r.req <= 1'b1;
            rd_r.addr <= src_r[pick];
            state_r <= dma_chan_pkg::ST_READ;
          end
        end
        dma_chan_pkg::ST_READ: begin
          if (rd_err) begin
            rd_r.req <= 1'b0;
            state_r <= dma_chan_pkg::ST_IDLE;
          end else if (rd_ack) begin
            rd_r.req <= 1'b0;
            wr_r.req <= 1'b1;
            wr_r.addr <= dst_r[cur_r];
            wr_data_r <= rd_data;
            state_r <= dma_chan_pkg::ST_WRITE;
          end
        end
        dma_chan_pkg::ST_WRITE: begin
          if (wr_err || wr_ack) begin
            wr_r.req <= 1'b0;
            state_r <= dma_chan_pkg::ST_IDLE;
          end
        end
        default: begin
          rd_r.req <= 1'b0;
          wr_r.req <= 1'b0;
          state_r <= dma_chan_pkg::ST_IDLE;
        end
      endcase
    end
  end

  function automatic logic [31:0] control_word(input int i);
    logic [31:0] w;
    w = 32'h00000000;
    w[`BIT_FAULT_ANY] = rerr_r[i] || werr_r[i];
    w[`BIT_FAULT_READ] = rerr_r[i];
    w[`BIT_FAULT_WRITE] = werr_r[i];
    w[`BIT_BUSY] = busy_r[i];
    w[`BIT_ENABLE] = en_r[i];
    return w;
  endfunction

  // Read data is prepared in the setup cycle, so every access has one wait-free cycle.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h00000000;
    case (rd_dec.sel)
      dma_chan_pkg::SEL_SOURCE: rd_mux = src_r[rd_dec.ch];
      dma_chan_pkg::SEL_DEST: rd_mux = dst_r[rd_dec.ch];
      dma_chan_pkg::SEL_TALLY,
      dma_chan_pkg::SEL_TALLY_TRIG: rd_mux = busy_r[rd_dec.ch] ? live_r[rd_dec.ch]
                                                                : reload_r[rd_dec.ch];
      dma_chan_pkg::SEL_CONTROL: rd_mux = control_word(32'(rd_dec.ch));
      dma_chan_pkg::SEL_RELOAD_DBG: rd_mux = reload_r[rd_dec.ch];
      dma_chan_pkg::SEL_INTR_STATUS: rd_mux[NUM_CH-1:0] = stat_r;
      dma_chan_pkg::SEL_INTR_MASK: rd_mux[NUM_CH-1:0] = mask_r;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h00000000;
    end else if (psel && !penable) begin
      pready_r <= 1'b1;
      pslverr_r <= rd_dec.sel == dma_chan_pkg::SEL_NONE;
      prdata_r <= (pwrite || rd_dec.sel == dma_chan_pkg::SEL_NONE) ? 32'h00000000 : rd_mux;
    end else begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign rd_req = rd_r;
  assign wr_req = wr_r;
  assign wr_data = wr_data_r;
  assign irq = irq_r;

  // Checks.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic [31:0] cur_src, cur_dst, cur_live;
  logic ctrl_setup, any_fail;
  assign cur_src = src_r[cur_r];
  assign cur_dst = dst_r[cur_r];
  assign cur_live = live_r[cur_r];
  assign ctrl_setup = psel && !penable && rd_dec.sel == dma_chan_pkg::SEL_CONTROL;
  assign any_fail = rd_fail || wr_fail;

  sequence s_read_ok;
    rd_done && !(wr_en && wd.sel == dma_chan_pkg::SEL_SOURCE && wd.ch == cur_r);
  endsequence
  sequence s_write_ok;
    wr_done && !(wr_en && wd.sel == dma_chan_pkg::SEL_DEST && wd.ch == cur_r);
  endsequence

  a_src_advance: assert property (s_read_ok |=> cur_src == $past(cur_src) + `XFER_BYTES)
    else $error("Read pointer did not advance by one transfer.");
  a_dst_advance: assert property (s_write_ok |=> cur_dst == $past(cur_dst) + `XFER_BYTES)
    else $error("Write pointer did not advance by one transfer.");
  a_live_count: assert property (wr_done |=> cur_live == $past(cur_live) - 32'h1)
    else $error("Live count did not drop on write completion.");
  // Another busy channel may start at once; only the faulted one must stay stopped.
  a_fault_halt: assert property (any_fail |=> state_r == dma_chan_pkg::ST_IDLE
    && !busy_r[cur_r] && stat_r[cur_r] ##1 !(rd_r.req && cur_r == $past(cur_r)) && !wr_r.req)
    else $error("Channel kept running or raised no flag after a bus error.");
  a_fault_or: assert property (ctrl_setup
    |=> prdata_r[31] == (prdata_r[30] || prdata_r[29]))
    else $error("Combined fault bit differs from the OR of the fault flags.");
  a_rsvd_zero: assert property (ctrl_setup |=> prdata_r[28:25] == 4'h0)
    else $error("Reserved control bits read nonzero.");
  a_trig_reload: assert property (wr_en && wd.sel == dma_chan_pkg::SEL_CONTROL
    && pwdata[`BIT_ENABLE] && !busy_r[wd.ch]
    |=> live_r[$past(wd.ch)] == $past(reload_r[wd.ch]))
    else $error("Trigger did not copy the reload value.");
  a_alias_len: assert property (wr_en && wd.sel == dma_chan_pkg::SEL_TALLY_TRIG
    && !busy_r[wd.ch] |=> live_r[$past(wd.ch)] == $past(pwdata)
    && reload_r[$past(wd.ch)] == $past(pwdata))
    else $error("Count trigger did not start with the written length.");
  a_pause_busy: assert property (state_r == dma_chan_pkg::ST_IDLE
    |=> (busy_r & $past(busy_r & ~en_r)) == $past(busy_r & ~en_r))
    else $error("Paused channel lost its busy flag.");
  a_rerr_sticky: assert property (rd_fail ##1 !(w1c_ctrl[cur_r] && pwdata[30]) [*2]
    |-> rerr_r[cur_r])
    else $error("Read fault flag did not hold until cleared.");

endmodule // dma_chan_core
`default_nettype wire

// ---- sim/bus_slave_model.sv ----
// Purpose: Behavioural system bus slave that answers the channel core's reads and writes.
// Assumes: One request per side at a time, answered by a one-cycle pulse.
// Notes: Idle read data is a running pattern, so stale data never looks like an answer.
`default_nettype none
module bus_slave_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Behaviour controls
  input wire logic slow,
  input wire logic fault_rd,
  input wire logic fault_wr,
  // Read side
  input wire dma_chan_pkg::bus_req_type rd_req,
  output logic rd_ack,
  output logic rd_err,
  output logic [31:0] rd_data,
  // Write side
  input wire dma_chan_pkg::bus_req_type wr_req,
  input wire logic [31:0] wr_data,
  output logic wr_ack,
  output logic wr_err,
  // Observation
  output logic [15:0] wr_cnt,
  output logic [31:0] last_addr,
  output logic [31:0] last_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] rd_wait_r;
  logic [2:0] wr_wait_r;
  logic [31:0] noise_r;
  logic [2:0] lat;
  assign lat = slow ? 3'h4 : 3'h0;
  assign rd_data = rd_ack ? (rd_req.addr ^ 32'ha5a5a5a5) : noise_r;
  always_ff @(posedge mclk) begin
    rd_ack <= 1'b0;
    rd_err <= 1'b0;
    noise_r <= noise_r * 32'h0019660d + 32'h3c6ef35f;
    if (!rst_n) begin
      rd_wait_r <= 3'h0;
      noise_r <= 32'h00000001;
    end else if (rd_req.req && !rd_ack && !rd_err) begin
      if (rd_wait_r == lat) begin
        rd_wait_r <= 3'h0;
        rd_ack <= !fault_rd;
        rd_err <= fault_rd;
      end else begin
        rd_wait_r <= rd_wait_r + 3'h1;
      end
    end
  end
  always_ff @(posedge mclk) begin
    wr_ack <= 1'b0;
    wr_err <= 1'b0;
    if (!rst_n) begin
      wr_wait_r <= 3'h0;
      wr_cnt <= 16'h0000;
    end else if (wr_req.req && !wr_ack && !wr_err) begin
      if (wr_wait_r == lat) begin
        wr_wait_r <= 3'h0;
        wr_ack <= !fault_wr;
        wr_err <= fault_wr;
        if (!fault_wr) begin
          wr_cnt <= wr_cnt + 16'h0001;
          last_addr <= wr_req.addr;
          last_data <= wr_data;
        end
      end else begin
        wr_wait_r <= wr_wait_r + 3'h1;
      end
    end
  end
endmodule // bus_slave_model
`default_nettype wire

// ---- sim/tb_dma_channel_pointer_count_status.sv ----
// Purpose: Self-checking bench for the channel pointer, count and status core.
// Assumes: The far side is the behavioural bus slave model.
// Notes: Expectations are worked out from the values the bench programs.
`include "dma_chan_cfg.svh"
`default_nettype none
module tb_dma_channel_pointer_count_status;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk, rst_n, psel, penable, pwrite, pready, pslverr, irq, qerr;
  logic rd_ack, rd_err, wr_ack, wr_err, slow, fault_rd, fault_wr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_data, wr_data, last_addr, last_data, q;
  logic [31:0] v [12];
  logic [15:0] wr_cnt, w0;
  dma_chan_pkg::bus_req_type rd_req, wr_req;
  int num_errors = 0;
  int check_count = 0;
  int c, k;
  dma_chan_core #(.NUM_CH(12)) DUT (.mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .rd_req, .rd_ack, .rd_err, .rd_data, .wr_req, .wr_data,
    .wr_ack, .wr_err, .irq);
  bus_slave_model far_side (.mclk, .rst_n, .slow, .fault_rd, .fault_wr, .rd_req, .rd_ack,
    .rd_err, .rd_data, .wr_req, .wr_data, .wr_ack, .wr_err, .wr_cnt, .last_addr, .last_data);
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Pready is sampled at the rising edge; the request stands until that edge has taken it.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    chk("pready", 32'h1, {31'h0, pready});
    if (pready !== 1'b1) tally_and_finish();
    q = prdata;
    qerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h00000000);
  endtask
  function automatic logic [11:0] ra(input int ch, input logic [5:0] off);
    return 12'(ch) * `CHAN_STRIDE + {6'h00, off};
  endfunction
  task automatic chk_irq(input logic e);
    @(negedge mclk);
    chk("irq", {31'h0, e}, {31'h0, irq});
    @(posedge mclk);
  endtask
  task automatic wait_idle(input int ch);
    int n;
    n = 0;
    do begin
      rd(ra(ch, `OFF_CONTROL));
      n++;
    end while (q[`BIT_BUSY] !== 1'b0 && n < 100);
    chk("busy at end", 32'h0, {31'h0, q[`BIT_BUSY]});
    if (q[`BIT_BUSY] !== 1'b0) tally_and_finish();
  endtask
  // Mode 0 writes the count then enables, 1 uses the count alias, 2 reuses the reload.
  task automatic run(input int ch, input int n, input int mode);
    logic [31:0] s, d;
    logic [15:0] c0;
    s = $urandom & 32'hfffffffc;
    d = $urandom & 32'hfffffffc;
    apb(1'b1, ra(ch, `OFF_SOURCE), s);
    apb(1'b1, ra(ch, `OFF_DEST), d);
    apb(1'b1, `ADDR_INTR_STATUS, 32'h1 << ch);
    c0 = wr_cnt;
    if (mode == 1) begin
      apb(1'b1, ra(ch, `OFF_TALLY_TRIG), n);
    end else begin
      if (mode == 0) apb(1'b1, ra(ch, `OFF_TALLY), n);
      apb(1'b1, ra(ch, `OFF_CONTROL), 32'h00000001);
    end
    if (slow) begin
      rd(ra(ch, `OFF_TALLY));
      chk("live count", n, q);
      rd(ra(ch, `OFF_CONTROL));
      chk("busy in run", 32'h1, {31'h0, q[`BIT_BUSY]});
    end
    wait_idle(ch);
    rd(ra(ch, `OFF_SOURCE));
    chk("source", s + `XFER_BYTES * n, q);
    rd(ra(ch, `OFF_DEST));
    chk("dest", d + `XFER_BYTES * n, q);
    chk("writes", n, {16'h0, wr_cnt - c0});
    chk("last addr", d + `XFER_BYTES * (n - 1), last_addr);
    chk("last data", (s + `XFER_BYTES * (n - 1)) ^ 32'ha5a5a5a5, last_data);
    rd(ra(ch, `OFF_TALLY));
    chk("reload", n, q);
    rd({`DBG_REGION, 10'h000} + ra(ch, `OFF_RELOAD_DBG));
    chk("reload view", n, q);
    rd(`ADDR_INTR_STATUS);
    chk("status bit", 32'h1, {31'h0, q[ch]});
  endtask
  // Reserved control bits are written as ones alongside the trigger.
  task automatic fault(input int ch, input logic r);
    logic [31:0] s;
    s = $urandom & 32'hfffffffc;
    // Every status bit is cleared first, so the status and irq checks below can trip.
    apb(1'b1, `ADDR_INTR_STATUS, 32'h00000fff);
    apb(1'b1, ra(ch, r ? `OFF_SOURCE : `OFF_DEST), s);
    apb(1'b1, ra(ch, `OFF_TALLY), 32'h00000003);
    fault_rd <= r;
    fault_wr <= !r;
    apb(1'b1, ra(ch, `OFF_CONTROL), 32'h1e000001);
    wait_idle(ch);
    fault_rd <= 1'b0;
    fault_wr <= 1'b0;
    chk("flags", {25'h0, 1'b1, r, !r, 4'h0}, {25'h0, q[31:25]});
    rd(ra(ch, r ? `OFF_SOURCE : `OFF_DEST));
    chk("fault pointer", 32'h1, {31'h0, (q - s) <= (r ? 32'd12 : 32'd20)});
    rd(`ADDR_INTR_STATUS);
    chk("fault status", 32'h1, {31'h0, q[ch]});
    chk_irq(1'b1);
    apb(1'b1, ra(ch, `OFF_CONTROL), r ? 32'h40000000 : 32'h20000000);
    rd(ra(ch, `OFF_CONTROL));
    chk("flags cleared", 32'h0, {29'h0, q[31:29]});
    apb(1'b1, `ADDR_INTR_STATUS, 32'h1 << ch);
    chk_irq(1'b0);
  endtask
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    slow = 1'b0;
    fault_rd = 1'b0;
    fault_wr = 1'b0;
    q = $urandom(47376);
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    for (c = 0; c < 12; c++) begin
      rd(ra(c, `OFF_SOURCE));
      chk("source reset", `PTR_RESET, q);
      rd(ra(c, `OFF_DEST));
      chk("dest reset", `PTR_RESET, q);
      rd(ra(c, `OFF_TALLY));
      chk("count reset", `TALLY_RESET, q);
    end
    rd(12'h300);
    chk("unmapped err", 32'h1, {31'h0, qerr});
    chk("unmapped data", 32'h0, q);
    for (c = 0; c < 12; c++) begin
      v[c] = $urandom;
      apb(1'b1, ra(c, `OFF_DEST), v[c]);
    end
    for (c = 0; c < 12; c++) begin
      rd(ra(c, `OFF_DEST));
      chk("dest readback", v[c], q);
    end
    c = $urandom_range(11);
    run(c, 2, 0);
    chk_irq(1'b0);
    apb(1'b1, `ADDR_INTR_MASK, 32'h00000fff);
    chk_irq(1'b1);
    apb(1'b1, `ADDR_INTR_STATUS, 32'h1 << c);
    chk_irq(1'b0);
    for (k = 0; k < 6; k++) begin
      slow <= k[0];
      c = $urandom_range(11);
      w0 = 16'($urandom_range(4, 1));
      run(c, w0, 0);
      run(c, w0, 2);
      run(c, $urandom_range(5, 1), 1);
    end
    fault($urandom_range(11), 1'b1);
    fault($urandom_range(11), 1'b0);
    c = $urandom_range(11);
    apb(1'b1, ra(c, `OFF_TALLY), 32'h00000004);
    w0 = wr_cnt;
    apb(1'b1, ra(c, `OFF_CONTROL), 32'h00000001);
    apb(1'b1, ra(c, `OFF_CONTROL), 32'h00000000);
    repeat (60) @(posedge mclk);
    rd(ra(c, `OFF_CONTROL));
    chk("busy paused", 32'h1, {31'h0, q[`BIT_BUSY]});
    chk("paused writes", 32'h1, {31'h0, (wr_cnt - w0) < 16'd4});
    apb(1'b1, ra(c, `OFF_CONTROL), 32'h00000001);
    wait_idle(c);
    chk("resumed writes", 32'h4, {16'h0, wr_cnt - w0});
    tally_and_finish();
  end
endmodule // tb_dma_channel_pointer_count_status
`default_nettype wire
